// ### rtl/pc_stack_indirect_addr.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`include "pc_stack_defines.svh"
// Behaviour
// RQ1: Keep a 13-bit program counter giving the next fetch address.
// RQ2: Low eight PC bits are pc_low_byte, readable and writable by software.
// RQ3: PC bits 12..8 sit in pc_high_bits, not directly accessible.
// RQ4: pc_high_bits load only from pc_high_holding_latch on upper updates.
// RQ5: Return stack of eight 13-bit entries outside program and data space.
// RQ6: Return-stack pointer is hidden from software.
// RQ7: Push PC on CALL and on interrupt branch. There is no interrupt branch here; only FLOW_CALL pushes.
// RQ8: Pop stack into PC on return, return_with_literal, return_from_interrupt. Only FLOW_RETURN pops here.
// RQ9: pc_high_holding_latch unchanged by push and pop.
// RQ10: Stack wraps circularly; ninth push overwrites the first entry.
// RQ11: indirect_data_window has no storage; access redirects via pointer_register.
// RQ12: Reading window with pointer_register zero returns zero.
// RQ13: Indirect write to the window itself stores nothing.
// RQ14: Effective address is indirect_bank_select above the 8-bit pointer.
// RQ15: indirect_bank_select has no effect; decode uses the pointer alone.
// RQ16: Stack pointer is a 3-bit up/down counter without overflow flags.
module pc_stack_indirect_addr #(
  parameter int DEPTH = `STACK_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire pc_stack_pkg::flow_req_t flow,
  input wire logic flow_valid,
  input wire logic advance,
  input wire logic [7:0] pc_low_wdata,
  input wire logic pc_low_we,
  input wire logic [4:0] latch_wdata,
  input wire logic latch_we,
  input wire logic [7:0] ptr_wdata,
  input wire logic ptr_we,
  input wire logic [7:0] status_reg,
  input wire pc_stack_pkg::data_req_t data_req,
  input wire logic [7:0] file_rdata,
  output logic [12:0] fetch_addr,
  output logic [7:0] pc_low_byte,
  output logic [4:0] pc_high_holding_latch,
  output logic [7:0] pointer_register,
  output logic [8:0] effective_addr,
  output logic [7:0] file_addr,
  output logic file_rd,
  output logic file_wr,
  output logic [7:0] file_wdata,
  output logic [7:0] data_rdata
);
  localparam logic [12:0] PC_RST = `PC_RESET;
  localparam logic [4:0] LATCH_RST = `LATCH_RESET;
  localparam logic [7:0] PTR_RST = `PTR_RESET;
  localparam logic [7:0] WIN_ADDR = `WINDOW_ADDR;
  localparam logic [2:0] SP_RST = 3'h0;
  localparam logic [2:0] SP_STEP = 3'h1;
  localparam logic [12:0] PC_STEP = 13'h0001;

  // Sequential fetch address, wraps at the top of program space
  function automatic logic [12:0] pc_inc(input logic [12:0] value);
    return value + PC_STEP;
  endfunction

  // Slot of the most recent push; wraps like the pointer itself
  function automatic logic [2:0] sp_prev(input logic [2:0] value);
    return value - SP_STEP;
  endfunction

  logic [4:0] pc_high_bits;
  logic [12:0] stack_mem [DEPTH];
  logic [2:0] sp;
  logic [12:0] pc;
  logic [12:0] next_pc;
  logic is_window;
  logic ind_target_zero;
  logic read_zero;
  logic is_call;
  logic is_return;
  logic is_jump;
  logic is_next;

  assign pc = {pc_high_bits, pc_low_byte}; // RQ1
  assign fetch_addr = pc;

  // One-hot view of the flow request, only while it is valid
  always_comb begin
    is_call = 1'b0;
    is_return = 1'b0;
    is_jump = 1'b0;
    is_next = 1'b0;
    if (flow_valid) begin
      case (flow.op)
        pc_stack_pkg::FLOW_CALL: is_call = 1'b1; // RQ7
        pc_stack_pkg::FLOW_RETURN: is_return = 1'b1; // RQ8
        pc_stack_pkg::FLOW_JUMP: is_jump = 1'b1;
        default: is_next = 1'b1;
      endcase
    end
  end

  // Next PC selection; call, jump and low-byte write take the upper bits from the holding latch
  always_comb begin
    next_pc = pc;
    if (flow_valid) begin
      case (flow.op)
        pc_stack_pkg::FLOW_CALL: next_pc = {pc_high_holding_latch, flow.target[7:0]}; // RQ4
        pc_stack_pkg::FLOW_JUMP: next_pc = {pc_high_holding_latch, flow.target[7:0]}; // RQ4
        pc_stack_pkg::FLOW_RETURN: next_pc = stack_mem[sp_prev(sp)]; // RQ8
        default: next_pc = pc_inc(pc);
      endcase
    end else if (pc_low_we) begin
      next_pc = {pc_high_holding_latch, pc_low_wdata}; // RQ2 RQ4
    end else if (advance) begin
      next_pc = pc_inc(pc);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pc_low_byte <= PC_RST[7:0];
      pc_high_bits <= PC_RST[12:8];
    end else begin
      pc_low_byte <= next_pc[7:0]; // RQ2
      pc_high_bits <= next_pc[12:8]; // RQ3
    end
  end

  // Holding latch written only by software, never by push or pop
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_high_holding_latch <= LATCH_RST;
    end else if (latch_we) begin
      pc_high_holding_latch <= latch_wdata; // RQ9
    end
  end

  // Return address is the instruction after the call site
  always_ff @(posedge clk) begin
    if (flow_valid && flow.op == pc_stack_pkg::FLOW_CALL) begin
      stack_mem[sp] <= pc_inc(pc); // RQ5 RQ7 RQ10
    end
  end

  // Hidden pointer, wraps silently in both directions
  always_ff @(posedge clk) begin
    if (srst) begin
      sp <= SP_RST;
    end else if (flow_valid && flow.op == pc_stack_pkg::FLOW_CALL) begin
      sp <= sp + 3'h1; // RQ6 RQ10 RQ16
    end else if (flow_valid && flow.op == pc_stack_pkg::FLOW_RETURN) begin
      sp <= sp_prev(sp); // RQ16
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pointer_register <= PTR_RST;
    end else if (ptr_we) begin
      pointer_register <= ptr_wdata;
    end
  end

  // Indirect window resolution
  assign is_window = (data_req.addr == `WINDOW_ADDR);
  assign ind_target_zero = (pointer_register == `WINDOW_ADDR);
  assign effective_addr = {status_reg[`BANK_SELECT_BIT], pointer_register}; // RQ14
  always_comb begin
    file_addr = data_req.addr;
    file_rd = data_req.rd;
    file_wr = data_req.wr;
    file_wdata = data_req.wdata;
    if (is_window) begin
      file_addr = effective_addr[7:0]; // RQ11 RQ15
      file_rd = data_req.rd && !ind_target_zero; // RQ12
      file_wr = data_req.wr && !ind_target_zero; // RQ13
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      read_zero <= 1'b0;
    end else begin
      read_zero <= data_req.rd && is_window && ind_target_zero;
    end
  end
  assign data_rdata = read_zero ? 8'h00 : file_rdata; // RQ12

  // Return stack and its hidden pointer
  chk_call_push: assert property (@(posedge clk) disable iff (srst) // RQ7
    is_call |=> sp == $past(sp) + SP_STEP)
    else $error("push did not advance pointer");

  chk_push_value: assert property (@(posedge clk) disable iff (srst) // RQ10
    is_call |=> stack_mem[$past(sp)] == $past(pc_inc(pc)))
    else $error("pushed value wrong");

  chk_return_pop: assert property (@(posedge clk) disable iff (srst) // RQ8
    is_return |=> pc == $past(stack_mem[sp_prev(sp)]))
    else $error("pop did not restore pc");

  chk_sp_pop: assert property (@(posedge clk) disable iff (srst) // RQ16
    is_return |=> sp == sp_prev($past(sp)))
    else $error("pop did not step pointer back");

  chk_sp_hold: assert property (@(posedge clk) disable iff (srst) // RQ16
    !is_call && !is_return |=> $stable(sp))
    else $error("pointer moved without stack op");

  chk_reset_state: assert property (@(posedge clk) // RQ1
    srst |=> pc == PC_RST && sp == SP_RST)
    else $error("reset state wrong");

  // Program counter and holding latch
  chk_latch_kept: assert property (@(posedge clk) disable iff (srst) // RQ9
    flow_valid && !latch_we |=> $stable(pc_high_holding_latch))
    else $error("latch changed on stack op");

  chk_latch_hold: assert property (@(posedge clk) disable iff (srst) // RQ9
    !latch_we |=> $stable(pc_high_holding_latch))
    else $error("latch changed without write");

  chk_latch_write: assert property (@(posedge clk) disable iff (srst) // RQ4
    latch_we |=> pc_high_holding_latch == $past(latch_wdata))
    else $error("latch write lost");

  chk_high_from_latch: assert property (@(posedge clk) disable iff (srst) // RQ4
    !flow_valid && pc_low_we |=> pc_high_bits == $past(pc_high_holding_latch))
    else $error("high bits not from latch");

  chk_jump_target: assert property (@(posedge clk) disable iff (srst) // RQ4
    is_call || is_jump |=> pc == {$past(pc_high_holding_latch), $past(flow.target[7:0])})
    else $error("jump target wrong");

  chk_low_write: assert property (@(posedge clk) disable iff (srst) // RQ2
    !flow_valid && pc_low_we |=> pc_low_byte == $past(pc_low_wdata))
    else $error("low byte write lost");

  chk_pc_advance: assert property (@(posedge clk) disable iff (srst) // RQ1
    !flow_valid && !pc_low_we && advance |=> pc == $past(pc) + PC_STEP)
    else $error("pc did not advance");

  chk_next_step: assert property (@(posedge clk) disable iff (srst) // RQ1
    is_next |=> pc == $past(pc) + PC_STEP)
    else $error("next op did not step pc");

  chk_pc_hold: assert property (@(posedge clk) disable iff (srst) // RQ1
    !flow_valid && !pc_low_we && !advance |=> $stable(pc))
    else $error("pc moved while idle");

  // Indirect window
  chk_ptr_write: assert property (@(posedge clk) disable iff (srst) // RQ11
    ptr_we |=> pointer_register == $past(ptr_wdata))
    else $error("pointer write lost");

  chk_ptr_hold: assert property (@(posedge clk) disable iff (srst) // RQ11
    !ptr_we |=> $stable(pointer_register))
    else $error("pointer changed without write");

  chk_redirect_addr: assert property (@(posedge clk) disable iff (srst) // RQ11
    is_window |-> file_addr == pointer_register)
    else $error("indirect address wrong");

  chk_window_wdata: assert property (@(posedge clk) disable iff (srst) // RQ11
    is_window |-> file_wdata == data_req.wdata)
    else $error("indirect write data wrong");

  chk_window_read: assert property (@(posedge clk) disable iff (srst) // RQ11
    data_req.rd && is_window && !ind_target_zero |-> file_rd)
    else $error("indirect read not issued");

  chk_direct_pass: assert property (@(posedge clk) disable iff (srst) // RQ11
    !is_window |-> file_addr == data_req.addr && file_rd == data_req.rd
      && file_wr == data_req.wr)
    else $error("direct access altered");

  chk_self_read_blocked: assert property (@(posedge clk) disable iff (srst) // RQ12
    data_req.rd && is_window && ind_target_zero |-> !file_rd)
    else $error("window self read reached file");

  chk_window_zero: assert property (@(posedge clk) disable iff (srst) // RQ12
    data_req.rd && is_window && ind_target_zero |=> data_rdata == 8'h00)
    else $error("window self read not zero");

  chk_window_rdata: assert property (@(posedge clk) disable iff (srst) // RQ12
    data_req.rd && !(is_window && ind_target_zero) |=> data_rdata == file_rdata)
    else $error("read data not passed on");

  chk_window_nowrite: assert property (@(posedge clk) disable iff (srst) // RQ13
    data_req.wr && is_window && ind_target_zero |-> !file_wr)
    else $error("window self write stored");

  cov_call_return: cover property (@(posedge clk) disable iff (srst)
    is_call ##[1:20] is_return);
  cov_wrap: cover property (@(posedge clk) disable iff (srst)
    is_call && sp == 3'h7);
  cov_jump: cover property (@(posedge clk) disable iff (srst)
    is_jump);
  cov_window_write: cover property (@(posedge clk) disable iff (srst)
    data_req.wr && is_window && !ind_target_zero);
  cov_self_read: cover property (@(posedge clk) disable iff (srst)
    data_req.rd && is_window && ind_target_zero);
endmodule

// ### rtl/pc_stack_defines.svh
`ifndef PC_STACK_DEFINES_SVH
`define PC_STACK_DEFINES_SVH
`define PC_WIDTH 13
`define PC_LOW_WIDTH 8
`define PC_HIGH_WIDTH 5
`define STACK_DEPTH 8
`define SP_WIDTH 3
`define PC_RESET 13'h0000
`define LATCH_RESET 5'h00
`define PTR_RESET 8'h00
`define WINDOW_ADDR 8'h00
`define BANK_SELECT_BIT 7
`endif

// ### rtl/pc_stack_pkg.sv
package pc_stack_pkg;
  typedef enum logic [1:0] {
    FLOW_NEXT,
    FLOW_CALL,
    FLOW_RETURN,
    FLOW_JUMP
  } flow_op_t;
  typedef struct packed {
    flow_op_t op;
    logic [12:0] target;
  } flow_req_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } data_req_t;
endpackage

// ### testbench/reg_file_model.sv
`timescale 1ns/1ns
module reg_file_model (
  input wire logic clk,
  input wire logic [7:0] file_addr,
  input wire logic file_rd,
  input wire logic file_wr,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5c;
  initial file_rdata = 8'h00;
  // Read data stands one cycle, then inverts so stale data never matches
  always @(posedge clk) begin
    file_rdata <= file_rd ? mem[file_addr] : ~file_rdata;
    if (file_wr) mem[file_addr] <= file_wdata;
  end
endmodule

// ### testbench/tb_pc_stack_indirect_addr.sv
`timescale 1ns/1ns
`include "pc_stack_defines.svh"
module tb_pc_stack_indirect_addr;
  logic clk = 1'b0, srst = 1'b1, flow_valid = 1'b0, advance = 1'b0, file_rd, file_wr;
  logic pc_low_we = 1'b0, latch_we = 1'b0, ptr_we = 1'b0;
  logic [7:0] pc_low_wdata = 8'h00, ptr_wdata = 8'h00, status_reg = 8'h00, file_rdata;
  logic [7:0] pc_low_byte, pointer_register, file_addr, file_wdata, data_rdata;
  logic [4:0] latch_wdata = 5'h00, pc_high_holding_latch;
  logic [12:0] fetch_addr, pc, push [10];
  logic [8:0] effective_addr;
  pc_stack_pkg::flow_req_t flow = '0;
  pc_stack_pkg::data_req_t data_req = '0;
  int err_total = 0, n_tests = 0;
  always #20 clk = ~clk;
  pc_stack_indirect_addr i_pc_stack_indirect_addr (.clk(clk), .srst(srst), .flow(flow),
    .flow_valid(flow_valid), .advance(advance), .pc_low_wdata(pc_low_wdata),
    .pc_low_we(pc_low_we), .latch_wdata(latch_wdata), .latch_we(latch_we),
    .ptr_wdata(ptr_wdata), .ptr_we(ptr_we), .status_reg(status_reg), .data_req(data_req),
    .file_rdata(file_rdata), .fetch_addr(fetch_addr), .pc_low_byte(pc_low_byte),
    .pc_high_holding_latch(pc_high_holding_latch), .pointer_register(pointer_register),
    .effective_addr(effective_addr), .file_addr(file_addr), .file_rd(file_rd),
    .file_wr(file_wr), .file_wdata(file_wdata), .data_rdata(data_rdata));
  reg_file_model i_reg_file_model (.clk(clk), .file_addr(file_addr), .file_rd(file_rd),
    .file_wr(file_wr), .file_wdata(file_wdata), .file_rdata(file_rdata));
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic fop(input pc_stack_pkg::flow_op_t op, input logic [7:0] t);
    @(posedge clk);
    flow <= '{op, {5'h1f, t}};
    flow_valid <= 1'b1;
  endtask
  task automatic idle();
    @(posedge clk);
    flow_valid <= 1'b0;
    advance <= 1'b0;
    pc_low_we <= 1'b0;
    latch_we <= 1'b0;
    ptr_we <= 1'b0;
    data_req <= '0;
    @(negedge clk);
  endtask
  task automatic acc(input logic [7:0] a, input logic rd, input logic [7:0] fa,
      input logic fw, input logic [7:0] rdat);
    @(posedge clk);
    data_req <= '{a, 8'h77, rd, ~rd};
    @(negedge clk);
    chk(file_addr, fa);
    chk(file_wr, fw);
    chk(file_wdata, 8'h77);
    chk(file_rd, rd && (fa != `WINDOW_ADDR || a != `WINDOW_ADDR));
    idle();
    if (rd) chk(data_rdata, rdat);
  endtask
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(fetch_addr, 13'h0000);
    @(posedge clk);
    latch_wdata <= 5'h0a;
    latch_we <= 1'b1;
    fop(pc_stack_pkg::FLOW_JUMP, 8'h10);
    idle();
    chk(fetch_addr, 13'h0a10);
    @(posedge clk);
    latch_wdata <= 5'h13;
    latch_we <= 1'b1;
    idle();
    pc = 13'h0a10;
    for (int i = 0; i < 10; i++) begin
      push[i] = pc + 13'h0001;
      pc = {5'h13, 8'h20 + 8'(i)};
      fop(pc_stack_pkg::FLOW_CALL, 8'h20 + 8'(i));
    end
    idle();
    chk(fetch_addr, pc);
    for (int i = 9; i >= 1; i--) begin
      fop(pc_stack_pkg::FLOW_RETURN, 8'h00);
      idle();
      chk(fetch_addr, push[i < 2 ? 9 : i]);
    end
    chk(pc_high_holding_latch, 5'h13);
    @(posedge clk);
    pc_low_wdata <= 8'h5a;
    pc_low_we <= 1'b1;
    @(posedge clk);
    pc_low_we <= 1'b0;
    advance <= 1'b1;
    idle();
    chk(pc_low_byte, 8'h5b);
    chk(fetch_addr, 13'h135b);
    fop(pc_stack_pkg::FLOW_NEXT, 8'h00);
    idle();
    chk(fetch_addr, 13'h135c);
    @(posedge clk);
    status_reg <= 8'h80;
    ptr_wdata <= 8'h05;
    ptr_we <= 1'b1;
    acc(`WINDOW_ADDR, 1'b1, 8'h05, 1'b0, 8'h59);
    chk(effective_addr, 9'h105);
    chk(pointer_register, 8'h05);
    acc(8'h07, 1'b1, 8'h07, 1'b0, 8'h5b);
    acc(`WINDOW_ADDR, 1'b0, 8'h05, 1'b1, 8'h00);
    acc(`WINDOW_ADDR, 1'b1, 8'h05, 1'b0, 8'h77);
    @(posedge clk);
    ptr_wdata <= 8'h00;
    ptr_we <= 1'b1;
    acc(`WINDOW_ADDR, 1'b1, 8'h00, 1'b0, 8'h00);
    acc(`WINDOW_ADDR, 1'b0, 8'h00, 1'b0, 8'h00);
    stop_test();
  end
endmodule
